//--- dcgoc_dev.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Writable serializer and deserializer addresses at 0x00, 0x01.
// - Host changes own device first, then paired.
// - Straps decode low, high or floating mid.
// - Lock makes 0x00 through 0x1F read only.
// - Only power-down or reset clears lock, never software.
// - Host keeps content protection off without partner.
// - Host uses 24/32-bit modes without high bandwidth.
// - Host avoids I2C-to-I2C without partner support.
// - Host sets 100mV reverse amplitude without coax.
// - Host uses legacy reverse channel without immunity.
// - Host uses two-channel audio without multichannel.
// - Host disables audio without partner audio.
// - Sync and enable inversion bits in 0x0E.
// - Audio clock inversion bits in 0x1D.
// - Two open-drain pins, controls at 0x06.
// - Zero pulls pin low, one releases it.
// - Pin levels always sampled into 0x06.
// - Host releases pin before using as input.
// - Staggered output delays by default.
// - Stagger disable gives all zero delay.
// - Control channel keeps pace up to 1Mbps.
// - Pin A can mirror encryption status.
// - Pin B can show authentication start.
module dcgoc_dev #(
  parameter logic [6:0] SER_ADDR_INIT = dcgoc_pkg::SER_ADDR_RST,
  parameter logic [6:0] DES_ADDR_INIT = dcgoc_pkg::DES_ADDR_RST
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control channel
  dcgoc_if.dev link,
  // Strap pins as threshold comparator outputs
  input wire logic cable_type_strap_hi,
  input wire logic cable_type_strap_lo,
  input wire logic bus_width_strap_hi,
  input wire logic bus_width_strap_lo,
  output dcgoc_pkg::dcgoc_strap_e cable_type_strap,
  output dcgoc_pkg::dcgoc_strap_e bus_width_strap,
  // Power-down pin
  input wire logic power_down_n,
  // Video sync path
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic de_in,
  output logic hsync_out,
  output logic vsync_out,
  output logic de_out,
  // Audio clocks
  input wire logic ws_in,
  input wire logic sck_in,
  output logic ws_out,
  output logic sck_out,
  // Open-drain pins
  input wire logic pin_a_i,
  output logic pin_a_o,
  output logic pin_a_oe,
  input wire logic pin_b_i,
  output logic pin_b_o,
  output logic pin_b_oe,
  // Security status from the receiver
  input wire logic encrypt_enabled,
  input wire logic auth_key_written,
  // Output stagger settings
  output logic [3:0][10:0] group_delay_ps,
  output logic [10:0] pixel_clock_out_delay_ps
);
  import dcgoc_pkg::*;

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [1:0] boot_cnt;
    dcgoc_strap_e ct_strap;
    dcgoc_strap_e bw_strap;
    logic [6:0] ser_addr;
    logic [6:0] des_addr;
    logic lock;
    logic [7:0] pin;
    logic [2:0] sync_inv;
    logic [1:0] aud_inv;
    logic enc_sel;
    logic auth_sel;
    logic auth_flag;
    logic ack;
    logic [7:0] rdata;
    logic [2:0] vid;
    logic [1:0] aud;
    logic pa_oe;
    logic pb_oe;
    logic [3:0][10:0] gdel;
    logic [10:0] pdel;
  } dcgoc_dev_s;

  dcgoc_dev_s r_reg;
  dcgoc_dev_s r_next;
  logic take;
  logic wr_ok;
  logic [7:0] wd;
  logic pa_val;
  logic pb_val;

  // Three-level decode: a floating pin trips neither comparator.
  function automatic dcgoc_strap_e strap_dec(input logic hi, input logic lo);
    if (hi) begin
      return STRAP_HIGH;
    end else if (lo) begin
      return STRAP_LOW;
    end else begin
      return STRAP_MID;
    end
  endfunction : strap_dec

  // Next-state logic for the whole end.
  always_comb begin
    r_next = r_reg;
    take = 1'b0;
    wr_ok = 1'b0;
    wd = link.wdata;
    pa_val = 1'b1;
    pb_val = 1'b1;
    // Pins cross two flops; the first stage feeds only the second.
    r_next.s1 = {power_down_n, cable_type_strap_hi, cable_type_strap_lo,
                 bus_width_strap_hi, bus_width_strap_lo, pin_a_i, pin_b_i};
    r_next.s2 = r_reg.s1;
    // Straps are caught once, after the synchronisers have filled.
    if (r_reg.boot_cnt != 2'd3) begin
      r_next.boot_cnt = r_reg.boot_cnt + 2'd1;
      if (r_reg.boot_cnt == 2'd2) begin
        r_next.ct_strap = strap_dec(r_reg.s2[5], r_reg.s2[4]);
        r_next.bw_strap = strap_dec(r_reg.s2[3], r_reg.s2[2]);
      end
    end
    // One-cycle answer per request, so any bit-level pacing is met.
    take = link.req & ~r_reg.ack;
    r_next.ack = take;
    // Writes into the locked range are answered but dropped.
    wr_ok = take & link.wr & ~(r_reg.lock & (link.addr <= LOCK_LAST));
    if (wr_ok) begin
      unique case (link.addr)
        REG_SER_ADDR: r_next.ser_addr = wd[7:ADDR_LSB];
        REG_DES_ADDR: begin
          r_next.des_addr = wd[7:ADDR_LSB];
          r_next.lock = wd[LOCK_BIT];
        end
        REG_PIN: begin
          r_next.pin[STAG_BIT] = wd[STAG_BIT];
          r_next.pin[AUTORST_BIT] = wd[AUTORST_BIT];
          r_next.pin[GPI_DIS_BIT] = wd[GPI_DIS_BIT];
          r_next.pin[PINB_DRV_BIT] = wd[PINB_DRV_BIT];
          r_next.pin[PINA_DRV_BIT] = wd[PINA_DRV_BIT];
        end
        REG_SYNC_INV: r_next.sync_inv = wd[2:0];
        REG_AUD_INV: r_next.aud_inv = wd[1:0];
        REG_FUNC: begin
          r_next.enc_sel = wd[ENC_SEL_BIT];
          r_next.auth_sel = wd[AUTH_SEL_BIT];
          r_next.auth_flag = wd[AUTH_FLAG_BIT] & r_reg.auth_flag;
        end
        default: ;
      endcase
    end
    // A key write sets the flag even in the cycle software clears it.
    if (auth_key_written) begin
      r_next.auth_flag = 1'b1;
    end
    // Power-down and reset are the only ways out of the lock.
    if (!r_reg.s2[6]) begin
      r_next.lock = 1'b0;
    end
    // Input buffers never switch off, so levels refresh every cycle.
    r_next.pin[PINA_LVL_BIT] = r_reg.s2[1];
    r_next.pin[PINB_LVL_BIT] = r_reg.s2[0];
    r_next.pin[4] = 1'b0;
    // Read data is taken from the registers as they stand.
    if (take) begin
      unique case (link.addr)
        REG_SER_ADDR: r_next.rdata = {r_reg.ser_addr, 1'b0};
        REG_DES_ADDR: r_next.rdata = {r_reg.des_addr, r_reg.lock};
        REG_PIN: r_next.rdata = r_reg.pin;
        REG_SYNC_INV: r_next.rdata = {5'h00, r_reg.sync_inv};
        REG_AUD_INV: r_next.rdata = {6'h00, r_reg.aud_inv};
        REG_FUNC: r_next.rdata = {5'h00, r_reg.auth_flag, r_reg.auth_sel, r_reg.enc_sel};
        default: r_next.rdata = 8'h00;
      endcase
    end
    // Internal polarity is active high; the bits flip the pins.
    r_next.vid = {de_in ^ r_reg.sync_inv[DE_INV_BIT],
                  vsync_in ^ r_reg.sync_inv[VS_INV_BIT],
                  hsync_in ^ r_reg.sync_inv[HS_INV_BIT]};
    r_next.aud = {ws_in ^ r_reg.aud_inv[WS_INV_BIT],
                  sck_in ^ r_reg.aud_inv[SCK_INV_BIT]};
    // Pin value: software bit, or a security status when selected.
    pa_val = r_reg.enc_sel ? encrypt_enabled : r_reg.pin[PINA_DRV_BIT];
    pb_val = r_reg.auth_sel ? r_reg.auth_flag : r_reg.pin[PINB_DRV_BIT];
    r_next.pa_oe = ~pa_val;
    r_next.pb_oe = ~pb_val;
    // Stagger codes drive the output delay cells of each group.
    if (r_reg.pin[STAG_BIT]) begin
      r_next.gdel = '0;
      r_next.pdel = 11'd0;
    end else begin
      r_next.gdel = {STAG_G3_PS, STAG_G2_PS, STAG_G1_PS, STAG_G0_PS};
      r_next.pdel = STAG_PCLK_PS;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.ct_strap <= STRAP_MID;
      r_reg.bw_strap <= STRAP_MID;
      r_reg.ser_addr <= SER_ADDR_INIT;
      r_reg.des_addr <= DES_ADDR_INIT;
      r_reg.pin <= PIN_RST;
      r_reg.gdel <= {STAG_G3_PS, STAG_G2_PS, STAG_G1_PS, STAG_G0_PS};
      r_reg.pdel <= STAG_PCLK_PS;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs come straight from state; pins only ever pull low.
  assign link.ack = r_reg.ack;
  assign link.rdata = r_reg.rdata;
  assign cable_type_strap = r_reg.ct_strap;
  assign bus_width_strap = r_reg.bw_strap;
  assign {de_out, vsync_out, hsync_out} = r_reg.vid;
  assign {ws_out, sck_out} = r_reg.aud;
  assign pin_a_o = 1'b0;
  assign pin_b_o = 1'b0;
  assign pin_a_oe = r_reg.pa_oe;
  assign pin_b_oe = r_reg.pb_oe;
  assign group_delay_ps = r_reg.gdel;
  assign pixel_clock_out_delay_ps = r_reg.pdel;

endmodule : dcgoc_dev

//--- dcgoc_host.sv
`timescale 1ns/1ps
module dcgoc_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control channel
  dcgoc_if.host link
);
  import dcgoc_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_GAP = 2'b10
  } dcgoc_hstate_e;

  typedef struct packed {
    dcgoc_hstate_e st;
    logic [4:0] gap;
    logic req;
    logic wr;
    logic chg;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
    logic refused;
    logic [6:0] cap;
    logic [1:0] pin_in;
    logic [7:0] pair_ser;
    logic [7:0] pair_des;
    logic [31:0] prdata;
  } dcgoc_host_s;

  dcgoc_host_s r_reg;
  dcgoc_host_s r_next;
  logic wr_acc;
  logic setup;
  logic bad;

  // A write the partner's missing features or input pins forbid.
  function automatic logic forbidden(input logic [6:0] cap, input logic [1:0] pin_in,
                                     input logic [7:0] a, input logic [7:0] d);
    logic f;
    f = 1'b0;
    for (int i = 0; i < FEAT_N; i++) begin
      if (cap[i] && a == FEAT_REG[i] && d[FEAT_BIT[i]] == FEAT_BAD[i]) begin
        f = 1'b1;
      end
    end
    if (a == REG_PIN && ((pin_in[0] & ~d[PINA_DRV_BIT]) | (pin_in[1] & ~d[PINB_DRV_BIT]))) begin
      f = 1'b1;
    end
    return f;
  endfunction : forbidden

  // Unmapped offsets answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(paddr == H_CMD || paddr == H_STAT ||
                                      paddr == H_CAP || paddr == H_PAIR);

  // Next-state logic.
  always_comb begin
    r_next = r_reg;
    setup = psel & ~penable;
    wr_acc = psel & penable & pwrite;
    bad = forbidden(r_reg.cap, r_reg.pin_in, pwdata[7:0], pwdata[15:8]);
    // Read data is latched in the setup cycle, valid in the access cycle.
    if (setup) begin
      unique case (paddr)
        H_STAT: r_next.prdata = {16'h0000, r_reg.rdata, 5'h00, r_reg.refused,
                                 r_reg.done, r_reg.st != H_IDLE};
        H_CAP: r_next.prdata = {22'h000000, r_reg.pin_in, 1'b0, r_reg.cap};
        H_PAIR: r_next.prdata = {16'h0000, r_reg.pair_des, r_reg.pair_ser};
        default: r_next.prdata = 32'h00000000;
      endcase
    end
    // Status flags clear by writing one; a new event still wins.
    if (wr_acc && paddr == H_STAT) begin
      r_next.done = r_reg.done & ~pwdata[1];
      r_next.refused = r_reg.refused & ~pwdata[2];
    end
    if (wr_acc && paddr == H_CAP) begin
      r_next.cap = pwdata[6:0];
      r_next.pin_in = pwdata[9:8];
    end
    if (wr_acc && paddr == H_CMD) begin
      if (r_reg.st != H_IDLE || (pwdata[CMD_WR_BIT] && bad)) begin
        r_next.refused = 1'b1;
      end else begin
        r_next.st = H_SEND;
        r_next.req = 1'b1;
        r_next.addr = pwdata[7:0];
        r_next.wdata = pwdata[15:8];
        r_next.wr = pwdata[CMD_WR_BIT];
        r_next.chg = pwdata[CMD_CHG_BIT] & pwdata[CMD_WR_BIT];
      end
    end
    unique case (r_reg.st)
      H_IDLE: ;
      H_SEND: begin
        if (link.ack) begin
          r_next.req = 1'b0;
          r_next.rdata = link.rdata;
          r_next.done = 1'b1;
          r_next.st = H_GAP;
          r_next.gap = 5'(CTRL_BIT_CYC - 1);
          // The paired copy follows only once the changed device took it.
          if (r_reg.chg && r_reg.addr == REG_SER_ADDR) begin
            r_next.pair_ser = r_reg.wdata;
          end
          if (r_reg.chg && r_reg.addr == REG_DES_ADDR) begin
            r_next.pair_des = r_reg.wdata;
          end
        end
      end
      H_GAP: begin
        if (r_reg.gap == 5'd0) begin
          r_next.st = H_IDLE;
        end else begin
          r_next.gap = r_reg.gap - 5'd1;
        end
      end
      default: r_next.st = H_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.pair_ser <= {SER_ADDR_RST, 1'b0};
      r_reg.pair_des <= {DES_ADDR_RST, 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign link.req = r_reg.req;
  assign link.wr = r_reg.wr;
  assign link.addr = r_reg.addr;
  assign link.wdata = r_reg.wdata;

endmodule : dcgoc_host

//--- dcgoc_if.sv
`timescale 1ns/1ps
interface dcgoc_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;

  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface : dcgoc_if

//--- dcgoc_pkg.sv
package dcgoc_pkg;

  // Register offsets of the deserializer end.
  localparam logic [7:0] REG_SER_ADDR = 8'h00;
  localparam logic [7:0] REG_DES_ADDR = 8'h01;
  localparam logic [7:0] REG_PIN = 8'h06;
  localparam logic [7:0] REG_SYNC_INV = 8'h0e;
  localparam logic [7:0] REG_FUNC = 8'h10;
  localparam logic [7:0] REG_AUD_INV = 8'h1d;
  localparam logic [7:0] LOCK_LAST = 8'h1f;

  // Field positions.
  localparam int ADDR_LSB = 1;
  localparam int LOCK_BIT = 0;
  localparam int STAG_BIT = 7;
  localparam int AUTORST_BIT = 6;
  localparam int GPI_DIS_BIT = 5;
  localparam int PINB_DRV_BIT = 3;
  localparam int PINB_LVL_BIT = 2;
  localparam int PINA_DRV_BIT = 1;
  localparam int PINA_LVL_BIT = 0;
  localparam int HS_INV_BIT = 0;
  localparam int VS_INV_BIT = 1;
  localparam int DE_INV_BIT = 2;
  localparam int SCK_INV_BIT = 0;
  localparam int WS_INV_BIT = 1;
  localparam int ENC_SEL_BIT = 0;
  localparam int AUTH_SEL_BIT = 1;
  localparam int AUTH_FLAG_BIT = 2;

  // Reset values.
  localparam logic [6:0] SER_ADDR_RST = 7'h40;
  localparam logic [6:0] DES_ADDR_RST = 7'h48;
  localparam logic [7:0] PIN_RST = 8'h0a;

  // Three-level strap codes.
  typedef enum logic [1:0] {
    STRAP_LOW = 2'b00,
    STRAP_MID = 2'b01,
    STRAP_HIGH = 2'b10
  } dcgoc_strap_e;

  // Output stagger delays in picoseconds.
  localparam logic [10:0] STAG_G0_PS = 11'd0;
  localparam logic [10:0] STAG_G1_PS = 11'd500;
  localparam logic [10:0] STAG_G2_PS = 11'd1000;
  localparam logic [10:0] STAG_G3_PS = 11'd1500;
  localparam logic [10:0] STAG_PCLK_PS = 11'd750;

  // Control channel pacing.
  localparam int CLK_HZ = 20_000_000;
  localparam int CTRL_BPS = 1_000_000;
  localparam int CTRL_BIT_CYC = CLK_HZ / CTRL_BPS;

  // Host APB map.
  localparam logic [11:0] H_CMD = 12'h000;
  localparam logic [11:0] H_STAT = 12'h004;
  localparam logic [11:0] H_CAP = 12'h008;
  localparam logic [11:0] H_PAIR = 12'h00c;
  localparam int CMD_WR_BIT = 16;
  localparam int CMD_CHG_BIT = 17;

  // Settings that a partner lacking feature i forbids: offset, bit, bad value.
  localparam int FEAT_N = 7;
  localparam logic [7:0] FEAT_REG [FEAT_N] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84,
                                               8'h85, 8'h02};
  localparam logic [2:0] FEAT_BIT [FEAT_N] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4};
  localparam logic FEAT_BAD [FEAT_N] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

endpackage : dcgoc_pkg

//--- dcgoc_properties.sv
`timescale 1ns/1ps
// Watches the control link between the two ends and the dev outputs that follow from it.
module dcgoc_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control link
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  // Dev hsync input and dev outputs
  input wire logic hsync_in,
  input wire logic hsync_out,
  input wire logic [3:0][10:0] group_delay_ps,
  input wire logic [10:0] pixel_clock_out_delay_ps
);
  import dcgoc_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A fresh request is answered exactly one cycle after it is taken.
  AST_ACK_NEXT: assert property ($rose(req) |=> ack) else $error("ack not next cycle");
  AST_ACK_PULSE: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  // The request and its qualifiers stand until the answer is seen.
  AST_REQ_HOLD: assert property ((req && !ack) |=> (req && $stable({wr, addr, wdata})))
    else $error("request changed before ack");
  // The host keeps the link paced after each transfer.
  AST_REQ_GAP: assert property ($fell(req) |-> !req [*8]) else $error("request too soon");
  // Read data moves only together with an answer; a dropped write is still answered and reloads it.
  AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata)) else $error("rdata moved");
  // With no request near, every input edge reaches the output one cycle later.
  AST_HSYNC_PATH: assert property ((!req && !$past(req) && !ack && $changed(hsync_in))
    |=> $changed(hsync_out)) else $error("hsync path broken");
  AST_STAG_ON: assert property ((pixel_clock_out_delay_ps == STAG_PCLK_PS)
    |-> (group_delay_ps == {STAG_G3_PS, STAG_G2_PS, STAG_G1_PS, STAG_G0_PS}))
    else $error("stagger set wrong");
  AST_STAG_OFF: assert property ((pixel_clock_out_delay_ps != STAG_PCLK_PS)
    |-> (group_delay_ps == '0 && pixel_clock_out_delay_ps == '0)) else $error("stagger off wrong");
endmodule : dcgoc_properties

//--- tb_top.sv
`timescale 1ns/1ps
// Drives both link ends through the host's APB port and checks the dev pins.
module tb_top;
  import dcgoc_pkg::*;
  // Table row: dev offset, byte written, byte read back.
  typedef struct packed {
    logic [7:0] off;
    logic [7:0] wd;
    logic [7:0] ex;
  } dcgoc_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ct_hi, ct_lo, bw_hi, bw_lo, power_down_n, ext_b_low, encrypt_enabled, auth_key_written;
  logic hsync_in, vsync_in, de_in, ws_in, sck_in, hsync_out, vsync_out, de_out, ws_out, sck_out;
  logic pin_a_i, pin_a_o, pin_a_oe, pin_b_i, pin_b_o, pin_b_oe;
  dcgoc_strap_e cable_type_strap, bus_width_strap;
  logic [3:0][10:0] group_delay_ps;
  logic [10:0] pixel_clock_out_delay_ps;
  logic [1:0] sc [3] = '{STRAP_LOW, STRAP_MID, STRAP_HIGH};
  int n_fail, checks_done, cycles;
  dcgoc_row_s rows [7];
  dcgoc_if link_if ();

`define CHK(nm, ex, got) begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
      n_fail++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

  // Pins are open drain with a pull-up; the bench may also pull pin B low.
  assign pin_a_i = pin_a_oe ? pin_a_o : 1'b1;
  assign pin_b_i = (pin_b_oe ? pin_b_o : 1'b1) & ~ext_b_low;

  dcgoc_host u_dcgoc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if));
  dcgoc_dev u_dcgoc_dev (.pclk(pclk), .presetn(presetn), .link(link_if),
    .cable_type_strap_hi(ct_hi), .cable_type_strap_lo(ct_lo), .bus_width_strap_hi(bw_hi),
    .bus_width_strap_lo(bw_lo), .cable_type_strap(cable_type_strap),
    .bus_width_strap(bus_width_strap), .power_down_n(power_down_n), .hsync_in(hsync_in),
    .vsync_in(vsync_in), .de_in(de_in), .hsync_out(hsync_out), .vsync_out(vsync_out),
    .de_out(de_out), .ws_in(ws_in), .sck_in(sck_in), .ws_out(ws_out), .sck_out(sck_out),
    .pin_a_i(pin_a_i), .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_i(pin_b_i),
    .pin_b_o(pin_b_o), .pin_b_oe(pin_b_oe), .encrypt_enabled(encrypt_enabled),
    .auth_key_written(auth_key_written), .group_delay_ps(group_delay_ps),
    .pixel_clock_out_delay_ps(pixel_clock_out_delay_ps));
  dcgoc_properties u_dcgoc_properties (.pclk(pclk), .presetn(presetn), .req(link_if.req),
    .wr(link_if.wr), .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack),
    .rdata(link_if.rdata), .hsync_in(hsync_in), .hsync_out(hsync_out),
    .group_delay_ps(group_delay_ps), .pixel_clock_out_delay_ps(pixel_clock_out_delay_ps));

  // Clock of 50 ns period.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // A hang is cut short well past the expected run length.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // One APB transfer; an idle cycle follows so the next setup never lands in this step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout may cut this wait short, so a stuck slave is counted.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // One dev access through the command register; waits while the host is busy.
  task automatic dev_op(input logic w, input logic c, input logic [7:0] o, input logic [7:0] d);
    apb(1'b1, H_STAT, 32'h6);
    apb(1'b1, H_CMD, {14'h0, c, w, d, o});
    // A host stuck busy is caught by the bench timeout, which counts it as a mismatch.
    do begin
      apb(1'b0, H_STAT, 32'h0);
    end while (rd[0] !== 1'b0);
  endtask : dev_op

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : do_reset

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ct_hi, bw_hi} = '0;
    {ct_lo, bw_lo, ext_b_low, encrypt_enabled, auth_key_written} = '0;
    {hsync_in, vsync_in, de_in, ws_in, sck_in} = '0;
    power_down_n = 1'b1;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    rows = '{'{8'h00, 8'h52, 8'h52}, '{8'h01, 8'h34, 8'h34}, '{8'h0e, 8'h07, 8'h07},
      '{8'h1d, 8'h03, 8'h03}, '{8'h06, 8'h8a, 8'h8f}, '{8'h06, 8'h08, 8'h0c},
      '{8'h30, 8'h55, 8'h00}};
    do_reset();
    foreach (rows[i]) begin
      dev_op(1'b1, 1'b0, rows[i].off, rows[i].wd);
      dev_op(1'b0, 1'b0, rows[i].off, 8'h00);
      `CHK("row", rows[i].ex, rd[15:8])
    end
    `CHK("pin_a_oe", 1'b1, pin_a_oe)
    `CHK("delays", {STAG_PCLK_PS, STAG_G3_PS}, {pixel_clock_out_delay_ps, group_delay_ps[3]})
    {hsync_in, vsync_in, de_in, ws_in, sck_in} <= 5'h1f;
    repeat (3) @(posedge pclk);
    `CHK("inverted", 5'h00, {hsync_out, vsync_out, de_out, ws_out, sck_out})
    dev_op(1'b1, 1'b0, REG_PIN, 8'h8a);
    `CHK("no stagger", 55'h0, {pixel_clock_out_delay_ps, group_delay_ps})
    ext_b_low <= 1'b1;
    dev_op(1'b0, 1'b0, REG_PIN, 8'h00);
    `CHK("pin level", 8'h8b, rd[15:8])
    ext_b_low <= 1'b0;
    // Pin functions follow the receiver status when selected.
    dev_op(1'b1, 1'b0, REG_FUNC, 8'h03);
    `CHK("pin_a_oe", 1'b1, pin_a_oe)
    encrypt_enabled <= 1'b1;
    auth_key_written <= 1'b1;
    @(posedge pclk);
    auth_key_written <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("pin oe", 2'b00, {pin_a_oe, pin_b_oe})
    dev_op(1'b0, 1'b0, REG_FUNC, 8'h00);
    `CHK("func", 8'h07, rd[15:8])
    dev_op(1'b1, 1'b0, REG_FUNC, 8'h00);
    encrypt_enabled <= 1'b0;
    // Settings forbidden by a missing partner feature, and an input pin driven low.
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, H_CAP, (i < 7) ? (32'h1 << i) : 32'h100);
      if (i < 7) begin
        dev_op(1'b1, 1'b0, FEAT_REG[i], 8'(FEAT_BAD[i]) << FEAT_BIT[i]);
      end else begin
        dev_op(1'b1, 1'b0, REG_PIN, 8'h88);
      end
      `CHK("refused", 1'b1, rd[2])
    end
    apb(1'b1, H_CAP, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    dev_op(1'b1, 1'b1, REG_SER_ADDR, 8'h66);
    apb(1'b0, H_PAIR, 32'h0);
    `CHK("pair", 8'h66, rd[7:0])
    // Lock, a dropped write, a software unlock attempt, then power-down.
    dev_op(1'b1, 1'b0, REG_DES_ADDR, 8'h35);
    dev_op(1'b1, 1'b0, REG_SER_ADDR, 8'h22);
    `CHK("acked", 1'b1, rd[1])
    dev_op(1'b0, 1'b0, REG_SER_ADDR, 8'h00);
    `CHK("locked", 8'h66, rd[15:8])
    dev_op(1'b1, 1'b0, REG_DES_ADDR, 8'h34);
    dev_op(1'b0, 1'b0, REG_DES_ADDR, 8'h00);
    `CHK("sticky", 8'h35, rd[15:8])
    power_down_n <= 1'b0;
    repeat (6) @(posedge pclk);
    power_down_n <= 1'b1;
    repeat (6) @(posedge pclk);
    dev_op(1'b1, 1'b0, REG_SER_ADDR, 8'h22);
    dev_op(1'b0, 1'b0, REG_SER_ADDR, 8'h00);
    `CHK("unlocked", 8'h22, rd[15:8])
    // Strap codes across repeated resets, then the reset register values.
    for (int i = 0; i < 3; i++) begin
      ct_hi <= (i == 2);
      ct_lo <= (i == 0);
      bw_hi <= (i == 0);
      bw_lo <= (i == 2);
      do_reset();
      `CHK("straps", {sc[i], sc[2 - i]}, {cable_type_strap, bus_width_strap})
    end
    dev_op(1'b0, 1'b0, REG_SER_ADDR, 8'h00);
    `CHK("ser addr", 8'h80, rd[15:8])
    dev_op(1'b0, 1'b0, REG_DES_ADDR, 8'h00);
    `CHK("des addr", 8'h90, rd[15:8])
    dev_op(1'b0, 1'b0, REG_PIN, 8'h00);
    `CHK("pin reg", 8'h0f, rd[15:8])
    complete_run();
  end
endmodule : tb_top
